// file: ils_defines.svh
`ifndef ILS_DEFINES_SVH
`define ILS_DEFINES_SVH
`define ILS_LAT_SIMPLE   5'h01
`define ILS_LAT_TRAP     5'h02
`define ILS_LAT_CR       5'h01
`define ILS_LAT_DIV      5'h13
`define ILS_LAT_MUL_MIN  5'h02
`define ILS_LAT_MUL_MAX  5'h06
`define ILS_LAT_MULI_MAX 5'h03
`define ILS_LAT_FDIVS    5'h11
`define ILS_LAT_FDIVD    5'h1F
`define ILS_LAT_FRES     5'h0A
`define ILS_LAT_FPSCR    5'h03
`define ILS_FP_STAGE1_SP 5'h01
`define ILS_FP_STAGE1_DP 5'h02
`define ILS_FP_STAGE_N   5'h01
`endif

// file: ils_pkg.sv
package ils_pkg;
  typedef enum logic [4:0] {
    ILS_CR_LOGIC, ILS_INT_SIMPLE, ILS_INT_CARRY, ILS_INT_TRAP, ILS_INT_MUL,
    ILS_INT_MULI, ILS_INT_DIV, ILS_FP_SIMPLE, ILS_FP_DBL_MUL, ILS_FP_STATUS_MOVE,
    ILS_FP_DIVS, ILS_FP_DIVD, ILS_FP_RECIP, ILS_FP_STATUS_WRITE,
    ILS_MEM_BARRIER, ILS_TLB_SYNC
  } ils_op_t;
  typedef enum logic [2:0] {
    ILS_UNIT_NONE, ILS_UNIT_SRU, ILS_UNIT_IA, ILS_UNIT_IB, ILS_UNIT_FP, ILS_UNIT_CB
  } ils_unit_t;
  typedef struct packed {
    logic    valid;
    ils_op_t op;
    logic [2:0] mul_lat;
  } ils_req_t;
  typedef struct packed {
    logic       valid;
    ils_unit_t  unit;
    logic [4:0] latency;
    logic       exec_serial;
    logic       finished;
  } ils_issue_t;
endpackage

// file: ils_scoreboard.sv
`timescale 1ns/100ps
`default_nettype none
`include "ils_defines.svh"
// Summary of operation
// - Barrier waits for queued stores drained
// - Barrier waits for bus broadcast success
// - TLB sync: completion buffer only, finished
// - TLB sync retires once sync input high
// - CR ops: system unit, 1 cycle, serialized
// - Integer unit A takes all integer ops
// - Integer unit B excludes multiply, divide
// - Divide 19 cycles, multiply 2 to 6
// - Simple 1, trap 2, carry ops serialized
// - Pipelined FP three stages, 1-1-1
// - Double multiply 2-1-1
// - Non-pipelined FP blocks; divides 17, 31
// - Reciprocal 10, status writes 3 cycles
module ils_scoreboard (
  input  wire logic           mclk,
  input  wire logic           resetn,
  input  wire ils_pkg::ils_req_t req,
  output logic                req_ready,
  output ils_pkg::ils_issue_t issue,
  output logic                result_ready,
  input  wire logic           retire_req,
  input  wire logic           store_queue_empty,
  input  wire logic           broadcast_enable,
  input  wire logic           broadcast_done,
  input  wire logic           tlb_invalidate_sync_in,
  output logic                retire_ok
);
  import ils_pkg::*;

  typedef enum {ST_IDLE, ST_BARRIER, ST_TLBS} ils_state_t;

  logic [4:0] busy_ia, busy_fp, result_cnt, next_lat;
  logic       bcast_seen;
  ils_unit_t  next_unit;
  logic       next_serial, ia_free, ib_free, fp_free, blocked;
  logic       use_ib;
  ils_state_t state;

  assign ia_free = (busy_ia == 5'h00);
  assign fp_free = (busy_fp == 5'h00);
  assign ib_free = 1'b1;

  always_comb begin
    next_unit   = ILS_UNIT_NONE;
    next_lat    = 5'h00;
    next_serial = 1'b0;
    use_ib      = !ia_free;
    case (req.op)
      ILS_CR_LOGIC: begin
        next_unit   = ILS_UNIT_SRU;
        next_lat    = `ILS_LAT_CR;
        next_serial = 1'b1;
      end
      ILS_INT_SIMPLE, ILS_INT_CARRY, ILS_INT_TRAP: begin
        next_unit   = use_ib ? ILS_UNIT_IB : ILS_UNIT_IA;
        next_lat    = (req.op == ILS_INT_TRAP) ? `ILS_LAT_TRAP : `ILS_LAT_SIMPLE;
        next_serial = (req.op == ILS_INT_CARRY);
      end
      ILS_INT_MUL: begin
        next_unit = ILS_UNIT_IA;
        next_lat  = (5'(req.mul_lat) < `ILS_LAT_MUL_MIN) ? `ILS_LAT_MUL_MIN :
                    (5'(req.mul_lat) > `ILS_LAT_MUL_MAX) ? `ILS_LAT_MUL_MAX :
                    5'(req.mul_lat);
      end
      ILS_INT_MULI: begin
        next_unit = ILS_UNIT_IA;
        next_lat  = (5'(req.mul_lat) >= `ILS_LAT_MULI_MAX) ? `ILS_LAT_MULI_MAX :
                    `ILS_LAT_MUL_MIN;
      end
      ILS_INT_DIV: begin
        next_unit = ILS_UNIT_IA;
        next_lat  = `ILS_LAT_DIV;
      end
      ILS_FP_SIMPLE, ILS_FP_STATUS_MOVE: begin
        next_unit   = ILS_UNIT_FP;
        next_lat    = `ILS_FP_STAGE1_SP + `ILS_FP_STAGE_N + `ILS_FP_STAGE_N;
        next_serial = (req.op == ILS_FP_STATUS_MOVE);
      end
      ILS_FP_DBL_MUL: begin
        next_unit = ILS_UNIT_FP;
        next_lat  = `ILS_FP_STAGE1_DP + `ILS_FP_STAGE_N + `ILS_FP_STAGE_N;
      end
      ILS_FP_DIVS: begin
        next_unit = ILS_UNIT_FP;
        next_lat  = `ILS_LAT_FDIVS;
      end
      ILS_FP_DIVD: begin
        next_unit = ILS_UNIT_FP;
        next_lat  = `ILS_LAT_FDIVD;
      end
      ILS_FP_RECIP: begin
        next_unit = ILS_UNIT_FP;
        next_lat  = `ILS_LAT_FRES;
      end
      ILS_FP_STATUS_WRITE: begin
        next_unit = ILS_UNIT_FP;
        next_lat  = `ILS_LAT_FPSCR;
      end
      ILS_MEM_BARRIER: begin
        next_unit = ILS_UNIT_SRU;
        next_lat  = 5'h01;
      end
      ILS_TLB_SYNC: begin
        next_unit = ILS_UNIT_CB;
        next_lat  = 5'h00;
      end
      default: begin
        next_unit = ILS_UNIT_NONE;
      end
    endcase
  end

  // Units that are still held busy refuse the request
  always_comb begin
    case (next_unit)
      ILS_UNIT_IA: blocked = !ia_free;
      ILS_UNIT_IB: blocked = !ib_free;
      ILS_UNIT_FP: blocked = !fp_free;
      default:     blocked = 1'b0;
    endcase
  end

  assign req_ready = !blocked && (result_cnt == 5'h00);

  // Divides and multiplies hold unit A for one cycle less than their latency
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_ia <= 5'h00;
    end else if (req.valid && req_ready && next_unit == ILS_UNIT_IA) begin
      busy_ia <= next_lat - 5'h01;
    end else if (busy_ia != 5'h00) begin
      busy_ia <= busy_ia - 5'h01;
    end
  end

  // Non-pipelined ops hold the FPU; pipelined ones hold only stage one
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy_fp <= 5'h00;
    end else if (req.valid && req_ready && next_unit == ILS_UNIT_FP) begin
      case (req.op)
        ILS_FP_DIVS, ILS_FP_DIVD, ILS_FP_RECIP, ILS_FP_STATUS_WRITE:
          busy_fp <= next_lat - 5'h01;
        ILS_FP_DBL_MUL:
          busy_fp <= `ILS_FP_STAGE1_DP - 5'h01;
        default:
          busy_fp <= `ILS_FP_STAGE1_SP - 5'h01;
      endcase
    end else if (busy_fp != 5'h00) begin
      busy_fp <= busy_fp - 5'h01;
    end
  end

  // Dependents are released when the latency has elapsed
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      result_cnt   <= 5'h00;
      result_ready <= 1'b0;
    end else if (req.valid && req_ready && next_lat != 5'h00) begin
      result_cnt   <= next_lat;
      result_ready <= 1'b0;
    end else begin
      result_cnt   <= (result_cnt != 5'h00) ? result_cnt - 5'h01 : 5'h00;
      result_ready <= (result_cnt == 5'h01);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      issue <= '0;
    end else begin
      issue.valid       <= req.valid && req_ready;
      issue.unit        <= next_unit;
      issue.latency     <= next_lat;
      issue.exec_serial <= next_serial;
      issue.finished    <= (req.op == ILS_TLB_SYNC);
    end
  end

  // Retirement of barrier and TLB sync
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (req.valid && req_ready && req.op == ILS_MEM_BARRIER) begin
            state <= ST_BARRIER;
          end else if (req.valid && req_ready && req.op == ILS_TLB_SYNC) begin
            state <= ST_TLBS;
          end
        end
        ST_BARRIER: begin
          if (retire_ok) begin
            state <= ST_IDLE;
          end
        end
        ST_TLBS: begin
          if (retire_ok) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      bcast_seen <= 1'b0;
    end else if (state != ST_BARRIER) begin
      bcast_seen <= 1'b0;
    end else if (broadcast_done) begin
      bcast_seen <= 1'b1;
    end
  end

  always_comb begin
    case (state)
      ST_BARRIER: retire_ok = retire_req && store_queue_empty &&
                              (!broadcast_enable || bcast_seen || broadcast_done);
      ST_TLBS:    retire_ok = retire_req && tlb_invalidate_sync_in;
      default:    retire_ok = retire_req;
    endcase
  end
endmodule
`default_nettype wire

// file: ils_sync_source.sv
`timescale 1ns/100ps
`default_nettype none
module ils_sync_source (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic stall,
  output logic      sync
);
  // Held high unless the bench asks for a slow system
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync <= 1'b1;
    end else begin
      sync <= !stall;
    end
  end
endmodule
`default_nettype wire

// file: ils_props.sv
`timescale 1ns/100ps
`default_nettype none
module ils_props (
  input wire logic                mclk,
  input wire logic                resetn,
  input wire ils_pkg::ils_req_t   req,
  input wire logic                req_ready,
  input wire ils_pkg::ils_issue_t issue,
  input wire logic                result_ready,
  input wire logic                retire_req,
  input wire logic                retire_ok
);
  import ils_pkg::*;
  wire          tk = req.valid && req_ready;
  wire ils_op_t op = req.op;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  cr_route_a: assert property (tk && op == ILS_CR_LOGIC |=> issue.valid &&
    issue.unit == ILS_UNIT_SRU && issue.exec_serial && issue.latency == 5'h01) else $error("cr");
  div_timing_a: assert property (tk && op == ILS_INT_DIV |=>
    issue.unit == ILS_UNIT_IA && issue.latency == 5'h13 ##19 result_ready) else $error("div");
  busy_refuse_a: assert property (tk && op inside {ILS_INT_DIV, ILS_FP_DIVS,
    ILS_FP_DIVD} |=> !req_ready [*8]) else $error("busy");
  mul_unit_a: assert property (tk && op inside {ILS_INT_MUL, ILS_INT_MULI} |=>
    issue.unit == ILS_UNIT_IA && issue.latency inside {[5'h02:5'h06]}) else $error("mul");
  trap_lat_a: assert property (tk && op == ILS_INT_TRAP |=>
    issue.latency == 5'h02 ##2 result_ready) else $error("trap");
  carry_serial_a: assert property (tk && op == ILS_INT_CARRY |=>
    issue.exec_serial) else $error("carry");
  fp_stage_a: assert property (tk && op == ILS_FP_DBL_MUL |=>
    issue.latency == 5'h04 ##4 result_ready) else $error("fp stages");
  fdiv_lat_a: assert property (tk && op == ILS_FP_DIVD |=> issue.unit == ILS_UNIT_FP &&
    issue.latency == 5'h1F ##31 result_ready) else $error("fdiv");
  recip_lat_a: assert property (tk && op == ILS_FP_RECIP |=>
    issue.latency == 5'h0A ##10 result_ready) else $error("recip");
  tlb_cb_a: assert property (tk && op == ILS_TLB_SYNC |=>
    issue.unit == ILS_UNIT_CB && issue.finished) else $error("tlb");
  retire_gate_a: assert property (retire_ok |-> retire_req) else $error("retire");
  cover property (tk && op == ILS_INT_DIV);
  cover property (tk && op == ILS_FP_DIVD);
  cover property (retire_req && retire_ok);
endmodule
bind ils_scoreboard ils_props u_props (.mclk, .resetn, .req, .req_ready, .issue,
  .result_ready, .retire_req, .retire_ok);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
  $display("unexpected %s expected %0h seen %0h", n, e, s); end end
module tb_top;
  import ils_pkg::*;
  logic       mclk, resetn, req_ready, result_ready, retire_req, retire_ok;
  logic       sq_empty, bc_en, bc_done, stall, sync;
  ils_req_t   req;
  ils_issue_t issue, g;
  int         fails, comparisons, c;
  ils_scoreboard u_ils_scoreboard (.mclk(mclk), .resetn(resetn), .req(req),
    .req_ready(req_ready), .issue(issue), .result_ready(result_ready), .retire_req(retire_req),
    .store_queue_empty(sq_empty), .broadcast_enable(bc_en), .broadcast_done(bc_done),
    .tlb_invalidate_sync_in(sync), .retire_ok(retire_ok));
  ils_sync_source u_ils_sync_source (.mclk(mclk), .resetn(resetn), .stall(stall), .sync(sync));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic step();
    @(posedge mclk);
    #1;
  endtask
  task automatic run_op(input ils_op_t op, input logic [2:0] ml, output ils_issue_t got,
                        output int cyc);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    `CHK("req ready", 1'b1, req_ready)
    req = '{1'b1, op, ml};
    step();
    req.valid = 1'b0;
    got = issue;
    cyc = 0;
    while (op != ILS_TLB_SYNC && result_ready !== 1'b1 && cyc < 40) begin
      step();
      cyc++;
    end
    if (op != ILS_TLB_SYNC) `CHK("result ready", 1'b1, result_ready)
  endtask
  task automatic t_int();
    run_op(ILS_CR_LOGIC, 3'h0, g, c);
    `CHK("cr unit", ILS_UNIT_SRU, g.unit)
    `CHK("cr serial", 1'b1, g.exec_serial)
    `CHK("cr cycles", 1, c)
    run_op(ILS_INT_DIV, 3'h0, g, c);
    `CHK("div unit", ILS_UNIT_IA, g.unit)
    `CHK("div cycles", 19, c)
    run_op(ILS_INT_MUL, 3'h5, g, c);
    `CHK("mul unit", ILS_UNIT_IA, g.unit)
    `CHK("mul cycles", 5, c)
    run_op(ILS_INT_MULI, 3'h6, g, c);
    `CHK("muli latency", 5'h03, g.latency)
    run_op(ILS_INT_MULI, 3'h3, g, c);
    `CHK("muli slow", 5'h03, g.latency)
    `CHK("muli cycles", 3, c)
    run_op(ILS_INT_TRAP, 3'h0, g, c);
    `CHK("trap cycles", 2, c)
    run_op(ILS_INT_CARRY, 3'h0, g, c);
    `CHK("carry serial", 1'b1, g.exec_serial)
    run_op(ILS_INT_SIMPLE, 3'h0, g, c);
    `CHK("simple cycles", 1, c)
    $display("test int done");
  endtask
  task automatic t_fp();
    ils_op_t    ops [6] = '{ILS_FP_SIMPLE, ILS_FP_DBL_MUL, ILS_FP_DIVS, ILS_FP_DIVD,
                           ILS_FP_RECIP, ILS_FP_STATUS_WRITE};
    logic [4:0] lat [6] = '{5'h03, 5'h04, 5'h11, 5'h1F, 5'h0A, 5'h03};
    for (int i = 0; i < 6; i++) begin
      run_op(ops[i], 3'h0, g, c);
      `CHK("fp latency", lat[i], g.latency)
      `CHK("fp cycles", int'(lat[i]), c)
    end
    run_op(ILS_FP_STATUS_MOVE, 3'h0, g, c);
    `CHK("fp move serial", 1'b1, g.exec_serial)
    $display("test fp done");
  endtask
  task automatic t_sync();
    run_op(ILS_MEM_BARRIER, 3'h0, g, c);
    sq_empty = 1'b0;
    retire_req = 1'b1;
    step();
    `CHK("barrier stores", 1'b0, retire_ok)
    sq_empty = 1'b1;
    bc_en = 1'b1;
    step();
    `CHK("barrier bcast", 1'b0, retire_ok)
    bc_done = 1'b1;
    #1;
    `CHK("barrier done", 1'b1, retire_ok)
    step();
    bc_done = 1'b0;
    retire_req = 1'b0;
    stall = 1'b1;
    run_op(ILS_TLB_SYNC, 3'h0, g, c);
    `CHK("tlb unit", ILS_UNIT_CB, g.unit)
    `CHK("tlb finished", 1'b1, g.finished)
    retire_req = 1'b1;
    step();
    `CHK("tlb stall", 1'b0, retire_ok)
    stall = 1'b0;
    step();
    `CHK("tlb retire", 1'b1, retire_ok)
    step();
    retire_req = 1'b0;
    $display("test sync done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    give_verdict();
  end
  initial begin
    {fails, comparisons} = '0;
    {resetn, retire_req, bc_en, bc_done, stall} = '0;
    sq_empty = 1'b1;
    req = '0;
    repeat (3) @(posedge mclk);
    #1;
    resetn = 1'b1;
    t_int();
    t_fp();
    t_sync();
    give_verdict();
  end
endmodule
`default_nettype wire
